// ==== logic/svr_debounce.sv ====
// manual reset input: three-stage sync plus low-level hold-off timer
`timescale 1ns/1ps
`default_nettype none

module svr_debounce #(
   parameter int unsigned DLY_CYC = svr_pkg::PB_DELAY_CYC
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // pin and result
   input wire logic i_level_n,
   output logic o_pressed
);

   logic s1_ff, s2_ff, s3_ff;
   logic acc_ff;
   logic [31:0] cnt_ff;
   logic pressed_ff;
   logic agree;
   logic [31:0] nxt_cnt;
   logic nxt_pressed;

   // ------------------------------------------------------------------
   // synchroniser, level accepted only when stages two and three agree
   // ------------------------------------------------------------------
   assign agree = (s2_ff == s3_ff);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
         acc_ff <= 1'b1;
      end else begin
         s1_ff <= i_level_n;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         acc_ff <= agree ? s3_ff : acc_ff;
      end
   end

   // ------------------------------------------------------------------
   // hold-off: short lows never reach the count, any high restarts it
   // ------------------------------------------------------------------
   assign nxt_cnt = acc_ff ? 32'h0 : (pressed_ff ? cnt_ff : 32'(cnt_ff + 32'h1));
   assign nxt_pressed = !acc_ff && (pressed_ff || (cnt_ff == DLY_CYC - 1));

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_ff <= 32'h0;
         pressed_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         pressed_ff <= nxt_pressed;
      end
   end

   assign o_pressed = pressed_ff;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   press_after_delay_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(pressed_ff) |-> $past(cnt_ff) == DLY_CYC - 1 && !$past(acc_ff))
      else $error("press flagged before the hold-off elapsed");
   release_drops_a: assert property (@(posedge i_clk) disable iff (i_rst)
      acc_ff |=> !pressed_ff)
      else $error("press flag stayed up after the input went high");

endmodule

`default_nettype wire

// ==== logic/svr_pkg.sv ====
// package: timing constants, pin bundle and select codes for the supervisor
package svr_pkg;

   // ------------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned RESET_ACTIVE_MS = 250;
   localparam int unsigned RESET_ACTIVE_CYC = RESET_ACTIVE_MS * CYC_PER_MS;
   localparam int unsigned TMO_LOW_MS = 150;
   localparam int unsigned TMO_OPEN_MS = 600;
   localparam int unsigned TMO_HIGH_MS = 1200;
   localparam int unsigned TMO_LOW_CYC = TMO_LOW_MS * CYC_PER_MS;
   localparam int unsigned TMO_OPEN_CYC = TMO_OPEN_MS * CYC_PER_MS;
   localparam int unsigned TMO_HIGH_CYC = TMO_HIGH_MS * CYC_PER_MS;
   // pushbutton delay: above the 1 ms ignore limit, below the 20 ms guarantee
   localparam int unsigned PB_DELAY_MS = 4;
   localparam int unsigned PB_DELAY_CYC = PB_DELAY_MS * CYC_PER_MS;

   // ------------------------------------------------------------------
   // pin codes and reset values
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      SVR_TSEL_LOW,
      SVR_TSEL_OPEN,
      SVR_TSEL_HIGH
   } svr_tsel_t;

   typedef struct packed {
      logic tol_high;
      logic [1:0] tsel;
      logic strobe_n;
      logic supply_ok;
   } svr_pins_t;

   localparam int unsigned PINS_W = 5;
   // supply starts as low so reset is held from the start
   localparam svr_pins_t PINS_RST = '{tol_high: 1'b0, tsel: 2'h1, strobe_n: 1'b1,
                                     supply_ok: 1'b0};

endpackage

// ==== logic/svr_top.sv ====
// supervisor: supply hold, manual reset, strobe watchdog, reset outputs
`timescale 1ns/1ps
`default_nettype none

module svr_top #(
   parameter int unsigned RST_CYC = svr_pkg::RESET_ACTIVE_CYC,
   parameter int unsigned TMO_LOW_CYC = svr_pkg::TMO_LOW_CYC,
   parameter int unsigned TMO_OPEN_CYC = svr_pkg::TMO_OPEN_CYC,
   parameter int unsigned TMO_HIGH_CYC = svr_pkg::TMO_HIGH_CYC,
   parameter int unsigned PB_DLY_CYC = svr_pkg::PB_DELAY_CYC
) (
   // clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RST,
   // supply comparator
   input wire logic I_SUPPLY_OK,
   input wire logic I_TOLERANCE_SELECT,
   output logic O_TOLERANCE_HIGH,
   // host side
   input wire logic I_MANUAL_RESET_N,
   input wire logic I_WATCHDOG_STROBE_N,
   input wire logic [1:0] I_TIMEOUT_SELECT,
   // reset outputs
   output logic O_RESET,
   output logic O_RESET_N_O,
   output logic O_RESET_N_OE
);

   svr_pkg::svr_pins_t raw, s1_ff, s2_ff, s3_ff, acc_ff;
   logic mr_pressed;
   logic strobe_prev_ff;
   logic strobe_fall;
   logic hold;
   logic wd_fire;
   logic rst_active;
   logic [31:0] limit;
   logic [31:0] stretch_ff, nxt_stretch;
   logic [31:0] wd_cnt_ff, nxt_wd_cnt;
   logic rst_ff, rst_n_oe_ff, rst_n_o_ff, tol_ff;
   logic [31:0] quiet_ff;

   function automatic logic [31:0] tmo_cycles(input logic [1:0] sel);
      case (sel)
         svr_pkg::SVR_TSEL_LOW: tmo_cycles = TMO_LOW_CYC;
         svr_pkg::SVR_TSEL_HIGH: tmo_cycles = TMO_HIGH_CYC;
         default: tmo_cycles = TMO_OPEN_CYC;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   assign raw = '{tol_high: I_TOLERANCE_SELECT, tsel: I_TIMEOUT_SELECT,
                  strobe_n: I_WATCHDOG_STROBE_N, supply_ok: I_SUPPLY_OK};

   // tsel bits settle one by one; a passing code 3 decodes as open
   genvar gi;
   generate
      for (gi = 0; gi < svr_pkg::PINS_W; gi++) begin : g_sync
         always_ff @(posedge I_SYS_CLK) begin
            if (I_RST) begin
               s1_ff[gi] <= svr_pkg::PINS_RST[gi];
               s2_ff[gi] <= svr_pkg::PINS_RST[gi];
               s3_ff[gi] <= svr_pkg::PINS_RST[gi];
               acc_ff[gi] <= svr_pkg::PINS_RST[gi];
            end else begin
               s1_ff[gi] <= raw[gi];
               s2_ff[gi] <= s1_ff[gi];
               s3_ff[gi] <= s2_ff[gi];
               acc_ff[gi] <= (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : acc_ff[gi];
            end
         end
      end
   endgenerate

   svr_debounce #(
      .DLY_CYC(PB_DLY_CYC)
   ) u_button (
      .i_clk(I_SYS_CLK),
      .i_rst(I_RST),
      .i_level_n(I_MANUAL_RESET_N),
      .o_pressed(mr_pressed)
   );

   // ------------------------------------------------------------------
   // reset stretcher
   // ------------------------------------------------------------------
   // any hold cause reloads the full interval, so a supply dip of two clocks or more restarts it
   assign hold = !acc_ff.supply_ok || mr_pressed;
   assign nxt_stretch = (hold || wd_fire) ? RST_CYC :
                        (stretch_ff != 32'h0) ? 32'(stretch_ff - 32'h1) : 32'h0;
   assign rst_active = hold || (stretch_ff != 32'h0);

   // ------------------------------------------------------------------
   // watchdog
   // ------------------------------------------------------------------
   // edge taken from the accepted level: a glitch under two clocks never restarts
   assign strobe_fall = strobe_prev_ff && !acc_ff.strobe_n;
   assign limit = tmo_cycles(acc_ff.tsel);
   // >= so a shorter select taking effect mid-count fires at once, never wraps
   assign wd_fire = !rst_active && !strobe_fall && (wd_cnt_ff >= limit - 1);
   assign nxt_wd_cnt = (rst_active || strobe_fall || wd_fire) ? 32'h0 :
                       32'(wd_cnt_ff + 32'h1);

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         stretch_ff <= RST_CYC;
         wd_cnt_ff <= 32'h0;
         strobe_prev_ff <= 1'b1;
      end else begin
         stretch_ff <= nxt_stretch;
         wd_cnt_ff <= nxt_wd_cnt;
         strobe_prev_ff <= acc_ff.strobe_n;
      end
   end

   // ------------------------------------------------------------------
   // outputs, both polarities from one decision
   // ------------------------------------------------------------------
   // open-drain low output: data is always 0, enable pulls the line
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         rst_ff <= 1'b1;
         rst_n_oe_ff <= 1'b1;
         rst_n_o_ff <= 1'b0;
         tol_ff <= 1'b0;
      end else begin
         rst_ff <= (nxt_stretch != 32'h0);
         rst_n_oe_ff <= (nxt_stretch != 32'h0);
         rst_n_o_ff <= 1'b0;
         tol_ff <= acc_ff.tol_high;
      end
   end

   assign O_RESET = rst_ff;
   assign O_RESET_N_OE = rst_n_oe_ff;
   assign O_RESET_N_O = rst_n_o_ff;
   assign O_TOLERANCE_HIGH = tol_ff;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   // cycles since the last hold cause, saturating; read only by checks
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST || hold) begin
         quiet_ff <= 32'h0;
      end else if (quiet_ff != 32'hffffffff) begin
         quiet_ff <= 32'(quiet_ff + 32'h1);
      end
   end

   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);

   power_up_a: assert property ($past(I_RST) |-> O_RESET)
      else $error("reset output not active after power-up");
   supply_hold_a: assert property (!acc_ff.supply_ok |=> O_RESET && O_RESET_N_OE)
      else $error("low supply did not hold reset");
   twin_outputs_a: assert property (O_RESET == O_RESET_N_OE && !O_RESET_N_O)
      else $error("reset outputs disagree");
   button_reset_a: assert property (mr_pressed |=> O_RESET)
      else $error("held button did not force reset");
   release_wait_a: assert property ($fell(O_RESET) |-> quiet_ff >= RST_CYC)
      else $error("reset released before the quiet interval");
   strobe_restart_a: assert property (strobe_fall |=> wd_cnt_ff == 32'h0)
      else $error("falling strobe did not restart the watchdog");
   rise_no_restart_a: assert property (
      $rose(acc_ff.strobe_n) && !rst_active && wd_cnt_ff < limit - 1 && wd_cnt_ff != 32'h0
      |=> wd_cnt_ff == $past(wd_cnt_ff) + 1)
      else $error("rising strobe disturbed the watchdog");
   missed_pulse_a: assert property (wd_fire |=> O_RESET && stretch_ff == RST_CYC)
      else $error("missed strobe gave no full reset pulse");
   frozen_in_reset_a: assert property (O_RESET |-> wd_cnt_ff == 32'h0)
      else $error("watchdog counted during reset");
   limit_select_a: assert property (
      acc_ff.tsel == svr_pkg::SVR_TSEL_LOW |-> limit == TMO_LOW_CYC)
      else $error("low select did not give the short timeout");

   // ------------------------------------------------------------------
   // counter steps and output relations: each counter reloads, clears or moves by one
   // ------------------------------------------------------------------
   hold_reload_a: assert property (hold |=> stretch_ff == RST_CYC && O_RESET)
      else $error("hold cause did not reload the reset interval");
   stretch_step_a: assert property (
      !hold && !wd_fire && stretch_ff != 32'h0 |=> stretch_ff == $past(stretch_ff) - 32'h1)
      else $error("reset interval did not count down by one");
   wd_step_a: assert property (
      !rst_active && !strobe_fall && !wd_fire |=> wd_cnt_ff == $past(wd_cnt_ff) + 32'h1)
      else $error("watchdog did not advance by one");
   wd_pulse_clear_a: assert property ($fell(rst_active) |-> wd_cnt_ff == 32'h0)
      else $error("watchdog not cleared at the end of reset");
   fire_when_idle_a: assert property (wd_fire |-> !O_RESET && !O_RESET_N_OE)
      else $error("watchdog fired while reset was active");
   idle_released_a: assert property (!rst_active |-> !O_RESET && !O_RESET_N_OE)
      else $error("reset output active with no cause");
   tol_follow_a: assert property (O_TOLERANCE_HIGH == $past(acc_ff.tol_high))
      else $error("tolerance output does not follow its strap");

   wd_fire_c: cover property (wd_fire ##1 O_RESET);
   button_c: cover property ($rose(mr_pressed));
   supply_drop_c: cover property ($fell(acc_ff.supply_ok));
   strobe_c: cover property (strobe_fall && !rst_active);
   strobe_rise_c: cover property ($rose(acc_ff.strobe_n) && !rst_active);

endmodule

`default_nettype wire

// ==== verif/svr_host.sv ====
// host processor model: strobes the watchdog and halts while held in reset
`timescale 1ns/1ps
`default_nettype none

module svr_host (
   // clock and control
   input wire logic i_clk,
   input wire logic i_run,
   input wire logic i_idle,
   // reset line, pulled up
   input wire logic i_reset_line_n,
   // strobe pin
   output logic o_strobe_n
);
   logic [3:0] cnt_ff;
   logic tog_ff;

   // stopped: the bench sets the pin level by hand
   assign o_strobe_n = i_run ? tog_ff : i_idle;

   always_ff @(posedge i_clk) begin
      if (!i_run) begin
         cnt_ff <= 4'h0;
         tog_ff <= i_idle;
      end else if (!i_reset_line_n) begin
         // halted processor leaves its port high
         cnt_ff <= 4'h0;
         tog_ff <= 1'b1;
      end else if (cnt_ff == 4'h5) begin
         cnt_ff <= 4'h0;
         tog_ff <= ~tog_ff;
      end else begin
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
endmodule

`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the supervisor with a strobing host model
`timescale 1ns/1ps
`default_nettype none

module tb;
   localparam int RST = 50;
   localparam int PB = 10;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sup = 1'b1;
   logic tolerance_select = 1'b0;
   logic mr_n = 1'b1;
   logic [1:0] tsel = 2'h0;
   logic run = 1'b0;
   logic idle = 1'b1;
   logic stb_n, rst_hi, rn_o, rn_oe, tol_hi;
   // open-drain line with its pull-up
   wire line_n = rn_oe ? rn_o : 1'b1;
   int bad_count = 0;
   int checks_done = 0;

   always #10 clk = ~clk;

   svr_top #(.RST_CYC(RST), .TMO_LOW_CYC(30), .TMO_OPEN_CYC(60), .TMO_HIGH_CYC(120),
      .PB_DLY_CYC(PB)) DUT (.I_SYS_CLK(clk), .I_RST(rst), .I_SUPPLY_OK(sup),
      .I_TOLERANCE_SELECT(tolerance_select), .O_TOLERANCE_HIGH(tol_hi), .I_MANUAL_RESET_N(mr_n),
      .I_WATCHDOG_STROBE_N(stb_n), .I_TIMEOUT_SELECT(tsel), .O_RESET(rst_hi),
      .O_RESET_N_O(rn_o), .O_RESET_N_OE(rn_oe));

   svr_host HOST (.i_clk(clk), .i_run(run), .i_idle(idle), .i_reset_line_n(line_n),
      .o_strobe_n(stb_n));

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input int got, input int lo, input int hi);
      checks_done++;
      if (got < lo || got > hi) begin
         bad_count++;
         $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask

   task automatic chk_bit(input string name, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // cycles until the reset output shows lvl, -1 if not seen
   task automatic wait_rst(input logic lvl, input int lim, input bit must, output int cnt);
      cnt = -1;
      for (int i = 1; i <= lim && cnt < 0; i++) begin
         @(negedge clk);
         chk_bit("reset_line_n", ~rst_hi, line_n);
         if (rst_hi === lvl) cnt = i;
      end
      if (must && cnt < 0) begin
         bad_count++;
         $display("ERROR reset wait expected %b seen %b", lvl, rst_hi);
         end_of_test();
      end
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_power();
      int n;
      @(posedge clk);
      rst <= 1'b0;
      run <= 1'b1;
      wait_rst(1'b0, RST + 10, 1'b1, n);
      chk("power-up hold", n, RST, RST + 8);
   endtask

   task automatic t_supply();
      int n;
      @(posedge clk);
      sup <= 1'b0;
      wait_rst(1'b1, 8, 1'b1, n);
      chk("supply drop", n, 1, 8);
      cyc(10);
      sup <= 1'b1;
      // a short dip must restart the whole hold
      cyc(20);
      sup <= 1'b0;
      cyc(3);
      sup <= 1'b1;
      wait_rst(1'b0, RST + 10, 1'b1, n);
      chk("supply restart", n, RST, RST + 8);
   endtask

   task automatic t_button();
      int n;
      @(posedge clk);
      mr_n <= 1'b0;
      cyc(PB / 2);
      mr_n <= 1'b1;
      wait_rst(1'b1, 30, 1'b0, n);
      chk("short press", n, -1, -1);
      @(posedge clk);
      mr_n <= 1'b0;
      wait_rst(1'b1, PB + 8, 1'b1, n);
      chk("press delay", n, PB, PB + 8);
      cyc(10);
      mr_n <= 1'b1;
      wait_rst(1'b0, RST + 10, 1'b1, n);
      chk("release hold", n, RST, RST + 8);
   endtask

   task automatic t_tol();
      for (int v = 0; v < 2; v++) begin
         @(posedge clk);
         tolerance_select <= ~v[0];
         cyc(6);
         @(negedge clk);
         chk_bit("tolerance", ~v[0], tol_hi);
      end
   endtask

   task automatic t_wdog(input logic [1:0] sel, input int lim);
      int n;
      int m;
      @(posedge clk);
      tsel <= sel;
      wait_rst(1'b1, 3 * lim, 1'b0, n);
      chk("strobed", n, -1, -1);
      @(posedge clk);
      run <= 1'b0;
      cyc(4);
      idle <= 1'b0;
      wait_rst(1'b1, lim / 2, 1'b0, n);
      chk("early fire", n, -1, -1);
      // a rising edge half way must not restart the count
      @(posedge clk);
      idle <= 1'b1;
      wait_rst(1'b1, lim + 10, 1'b1, m);
      chk("timeout", lim / 2 + m, lim, lim + 8);
      wait_rst(1'b0, RST + 4, 1'b1, n);
      chk("pulse width", n, RST - 1, RST + 1);
      wait_rst(1'b1, lim + 4, 1'b1, n);
      chk("repeat", n, lim - 2, lim + 3);
      @(posedge clk);
      run <= 1'b1;
      wait_rst(1'b0, RST + 4, 1'b1, n);
      wait_rst(1'b1, 2 * lim, 1'b0, n);
      chk("resumed", n, -1, -1);
      $display("done: watchdog limit %0d", lim);
   endtask

   initial begin
      cyc(1);
      t_power();
      $display("done: power-up");
      t_supply();
      $display("done: supply");
      t_button();
      $display("done: button");
      t_tol();
      $display("done: tolerance");
      t_wdog(svr_pkg::SVR_TSEL_LOW, 30);
      t_wdog(svr_pkg::SVR_TSEL_OPEN, 60);
      t_wdog(svr_pkg::SVR_TSEL_HIGH, 120);
      end_of_test();
   end
endmodule

`default_nettype wire
